//--- include/ssc_pkg.sv
// package of constants and types for the safe standstill control block
package ssc_pkg;
    localparam int SSC_NUM_DRIVES = 4;
    localparam int SSC_NUM_DI = 8;
    localparam int SSC_NUM_DI_EXP = 4;
    localparam int SSC_SEL_W = 3;
    localparam int SSC_NUM_FDO = 4;
    // fail-safe input channel positions
    localparam int SSC_CH_ESTOP_A = 0;
    localparam int SSC_CH_ESTOP_B = 4;
    localparam int SSC_CH_DOOR_A = 1;
    localparam int SSC_CH_DOOR_B = 5;
    localparam int SSC_CH_AGREE_A = 2;
    localparam int SSC_CH_AGREE_B = 6;
    localparam int SSC_CH_DRON_A = 3;
    localparam int SSC_CH_DRON_B = 7;
    // enable bit position within each enable parameter
    localparam int SSC_EN_BIT = 0;
    // valve output channel
    localparam int SSC_FDO_VALVE = 0;
    // standstill status bit positions
    localparam int SSC_ST_ACTIVE = 0;
    localparam int SSC_ST_FAULT = 1;
    localparam logic [3:0] SSC_DRIVE_MASK_RST = 4'h0;
    localparam logic [1:0] SSC_PAIR_RST = 2'h0;

    typedef enum logic [1:0] {
        SSC_RS_STANDSTILL,
        SSC_RS_WAIT_LOW,
        SSC_RS_WAIT_HIGH,
        SSC_RS_RUN
    } ssc_restart_type;
endpackage

//--- logic/ssc_pair_decode.sv
// decoder for one two-channel fail-safe sensor pair
module ssc_pair_decode
    import ssc_pkg::*;
#(
    parameter bit ANTIVALENT = 1'b0,
    parameter bit ACTIVE_HIGH = 1'b1
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ch_a,
    input wire logic ch_b,
    output logic active_reg,
    output logic discrepancy_reg
);
    logic valid;
    logic level;

    // equivalent pairs must agree, antivalent pairs must differ
    assign valid = ANTIVALENT ? (ch_a ^ ch_b) : (ch_a ~^ ch_b);
    assign level = ch_a ~^ ACTIVE_HIGH;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            // reset lands on the safe meaning, whatever the active level
            active_reg <= ~ACTIVE_HIGH;
            discrepancy_reg <= 1'b0;
        end else begin
            // illegal pattern falls to the safe meaning, level 0 on channel a
            active_reg <= valid ? level : ~ACTIVE_HIGH;
            discrepancy_reg <= ~valid;
        end
    end
endmodule

//--- logic/ssc_top.sv
// safe standstill selection, supervision, restart, brake trigger and sensor I/O
// Summary of operation
// - per drive, control-unit and motor-module standstill inputs
// - control-unit source selectable from inputs 0..7
// - expansion variant offers only inputs 0..3
// - fault when the two channels disagree
// - groups share one selected input; each drive keeps its own enable
// - drive fault never spreads standstill to group
// - separate enable bit 0 per channel
// - disabled supervision leaves all inputs free
// - input 1 deselects, input 0 selects standstill
// - selection stops only the selected drive; drives sharing its input see it in group status
// - status per channel, combined and group
// - brake triggered by standstill or pulse cancel
// - brake output de-energized engages brake
// - emergency stop on channels 0 and 4
// - door interlock on channels 1 and 5
// - agreement button antivalent on channels 2, 6
// - drives-on button on channels 3 and 7
// - each fail-safe output switched off independently
// - valve output 0 low locks, high flows
// - power-on command acts on a falling edge, then a rising edge
module ssc_top
    import ssc_pkg::*;
#(
    parameter int NUM_DRIVES = SSC_NUM_DRIVES,
    parameter bit EXPANSION_UNIT = 1'b0
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic [SSC_NUM_DI-1:0] DIGITAL_IN,
    input wire logic [NUM_DRIVES*SSC_SEL_W-1:0] STANDSTILL_SOURCE_SELECT,
    input wire logic [NUM_DRIVES-1:0] PULSE_ENABLE_TERMINAL,
    input wire logic [NUM_DRIVES-1:0] CU_STANDSTILL_ENABLE,
    input wire logic [NUM_DRIVES-1:0] MM_STANDSTILL_ENABLE,
    input wire logic [NUM_DRIVES-1:0] DRIVE_ENABLE,
    input wire logic [NUM_DRIVES-1:0] POWER_ON_COMMAND,
    input wire logic [NUM_DRIVES-1:0] DRIVE_FAULT,
    input wire logic [NUM_DRIVES-1:0] MONITOR_PULSE_CANCEL,
    input wire logic [SSC_NUM_DI-1:0] FAILSAFE_INPUT_MODULE,
    input wire logic [SSC_NUM_FDO-1:0] FAILSAFE_OUT_CMD,
    output logic [NUM_DRIVES-1:0] CU_SAFETY_STATUS,
    output logic [NUM_DRIVES-1:0] MM_SAFETY_STATUS,
    output logic [NUM_DRIVES-1:0] COMBINED_SAFETY_STATUS,
    output logic [NUM_DRIVES-1:0] GROUP_SAFETY_STATUS,
    output logic [NUM_DRIVES-1:0] DISCREPANCY_FAULT,
    output logic [NUM_DRIVES-1:0] PULSES_ENABLED,
    output logic [NUM_DRIVES-1:0] SAFE_BRAKE_CTRL,
    output logic [NUM_DRIVES-1:0] GENERAL_DI_FREE,
    output logic [SSC_NUM_DI-1:0] DIGITAL_IN_GENERAL,
    output logic ESTOP_PRESSED,
    output logic DOOR_INTERLOCKED,
    output logic AGREEMENT_PRESSED,
    output logic DRIVES_ON_PRESSED,
    output logic [3:0] SENSOR_DISCREPANCY,
    output logic [SSC_NUM_FDO-1:0] FAILSAFE_OUT_P,
    output logic [SSC_NUM_FDO-1:0] FAILSAFE_OUT_M,
    output logic VALVE_FLOW
);
    localparam int DI_AVAIL = EXPANSION_UNIT ? SSC_NUM_DI_EXP : SSC_NUM_DI;

    // refused at elaboration: the per-drive buses are sized for this range only
    if (NUM_DRIVES < 1 || NUM_DRIVES > 32) begin
        $error("ssc_top: NUM_DRIVES must be 1 to 32");
    end

    logic [NUM_DRIVES-1:0] cu_select;
    logic [NUM_DRIVES-1:0] cu_standstill;
    logic [NUM_DRIVES-1:0] mm_standstill;
    logic [NUM_DRIVES-1:0] both_standstill;
    logic [NUM_DRIVES-1:0] group_standstill;
    logic [NUM_DRIVES-1:0] mismatch;
    logic [NUM_DRIVES-1:0] pwr_on_prev_reg;
    logic [NUM_DRIVES-1:0] pwr_rise;
    logic [NUM_DRIVES-1:0] pwr_fall;
    logic [NUM_DRIVES-1:0] run_now;
    ssc_restart_type rs_reg [NUM_DRIVES];
    ssc_restart_type rs_next [NUM_DRIVES];

    // per-drive source selection and channel decode
    always_comb begin
        for (int d = 0; d < NUM_DRIVES; d++) begin
            logic [SSC_SEL_W-1:0] sel;
            sel = STANDSTILL_SOURCE_SELECT[d*SSC_SEL_W +: SSC_SEL_W];
            // out-of-range selection on the small variant reads as de-energized
            if (int'(sel) < DI_AVAIL) begin
                cu_select[d] = DIGITAL_IN[sel];
            end else begin
                cu_select[d] = 1'b0;
            end
            // de-energized input selects standstill
            cu_standstill[d] = CU_STANDSTILL_ENABLE[d] & ~cu_select[d];
            mm_standstill[d] = MM_STANDSTILL_ENABLE[d] & ~PULSE_ENABLE_TERMINAL[d];
            both_standstill[d] = cu_standstill[d] | mm_standstill[d];
            mismatch[d] = CU_STANDSTILL_ENABLE[d] & MM_STANDSTILL_ENABLE[d]
                & (cu_select[d] ^ PULSE_ENABLE_TERMINAL[d]);
        end
    end

    // group standstill: my own standstill plus the control-unit standstill of every
    // drive sharing my source selection; a drive fault alone is deliberately not included
    always_comb begin
        for (int d = 0; d < NUM_DRIVES; d++) begin
            group_standstill[d] = both_standstill[d];
            for (int e = 0; e < NUM_DRIVES; e++) begin
                if (STANDSTILL_SOURCE_SELECT[e*SSC_SEL_W +: SSC_SEL_W]
                    == STANDSTILL_SOURCE_SELECT[d*SSC_SEL_W +: SSC_SEL_W]) begin
                    group_standstill[d] = group_standstill[d] | cu_standstill[e];
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            pwr_on_prev_reg <= '0;
        end else begin
            pwr_on_prev_reg <= POWER_ON_COMMAND;
        end
    end

    assign pwr_rise = POWER_ON_COMMAND & ~pwr_on_prev_reg;
    assign pwr_fall = ~POWER_ON_COMMAND & pwr_on_prev_reg;

    // restart sequence per drive
    always_comb begin
        for (int d = 0; d < NUM_DRIVES; d++) begin
            rs_next[d] = rs_reg[d];
            unique case (rs_reg[d])
                SSC_RS_STANDSTILL: begin
                    if (!both_standstill[d] && !mismatch[d] && DRIVE_ENABLE[d]) begin
                        rs_next[d] = SSC_RS_WAIT_LOW;
                    end
                end
                SSC_RS_WAIT_LOW: begin
                    if (pwr_fall[d]) begin
                        rs_next[d] = SSC_RS_WAIT_HIGH;
                    end
                end
                SSC_RS_WAIT_HIGH: begin
                    if (pwr_rise[d]) begin
                        rs_next[d] = SSC_RS_RUN;
                    end
                end
                SSC_RS_RUN: begin
                end
            endcase
            // any loss of conditions drops back to standstill
            if (both_standstill[d] || mismatch[d] || !DRIVE_ENABLE[d]
                || DRIVE_FAULT[d] || MONITOR_PULSE_CANCEL[d]) begin
                rs_next[d] = SSC_RS_STANDSTILL;
            end
            run_now[d] = (rs_next[d] == SSC_RS_RUN);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        for (int d = 0; d < NUM_DRIVES; d++) begin
            if (!RESET_N) begin
                rs_reg[d] <= SSC_RS_STANDSTILL;
            end else begin
                rs_reg[d] <= rs_next[d];
            end
        end
    end

    // status outputs
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            CU_SAFETY_STATUS <= '1;
            MM_SAFETY_STATUS <= '1;
            COMBINED_SAFETY_STATUS <= '1;
            GROUP_SAFETY_STATUS <= '1;
            DISCREPANCY_FAULT <= '0;
        end else begin
            CU_SAFETY_STATUS <= cu_standstill;
            MM_SAFETY_STATUS <= mm_standstill;
            COMBINED_SAFETY_STATUS <= cu_standstill & mm_standstill;
            GROUP_SAFETY_STATUS <= group_standstill;
            DISCREPANCY_FAULT <= mismatch;
        end
    end

    // pulses and brake; brake energized only while running
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            PULSES_ENABLED <= '0;
            SAFE_BRAKE_CTRL <= '0;
        end else begin
            PULSES_ENABLED <= run_now;
            // standstill or pulse cancel de-energizes, so the brake engages
            SAFE_BRAKE_CTRL <= run_now & ~both_standstill & ~MONITOR_PULSE_CANCEL;
        end
    end

    // inputs stay usable as plain inputs when no supervision claims them
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            GENERAL_DI_FREE <= '0;
            DIGITAL_IN_GENERAL <= '0;
        end else begin
            GENERAL_DI_FREE <= ~CU_STANDSTILL_ENABLE;
            DIGITAL_IN_GENERAL <= DIGITAL_IN;
        end
    end

    // fail-safe sensor pairs
    // active level inverted so the pressed state comes straight from the flop
    ssc_pair_decode #(.ANTIVALENT(1'b0), .ACTIVE_HIGH(1'b0)) u_estop (
        .clk_sys(CLK_SYS),
        .reset_n(RESET_N),
        .ch_a(FAILSAFE_INPUT_MODULE[SSC_CH_ESTOP_A]),
        .ch_b(FAILSAFE_INPUT_MODULE[SSC_CH_ESTOP_B]),
        .active_reg(ESTOP_PRESSED),
        .discrepancy_reg(SENSOR_DISCREPANCY[0])
    );

    ssc_pair_decode #(.ANTIVALENT(1'b0), .ACTIVE_HIGH(1'b1)) u_door (
        .clk_sys(CLK_SYS),
        .reset_n(RESET_N),
        .ch_a(FAILSAFE_INPUT_MODULE[SSC_CH_DOOR_A]),
        .ch_b(FAILSAFE_INPUT_MODULE[SSC_CH_DOOR_B]),
        .active_reg(DOOR_INTERLOCKED),
        .discrepancy_reg(SENSOR_DISCREPANCY[1])
    );

    ssc_pair_decode #(.ANTIVALENT(1'b1), .ACTIVE_HIGH(1'b1)) u_agree (
        .clk_sys(CLK_SYS),
        .reset_n(RESET_N),
        .ch_a(FAILSAFE_INPUT_MODULE[SSC_CH_AGREE_A]),
        .ch_b(FAILSAFE_INPUT_MODULE[SSC_CH_AGREE_B]),
        .active_reg(AGREEMENT_PRESSED),
        .discrepancy_reg(SENSOR_DISCREPANCY[2])
    );

    ssc_pair_decode #(.ANTIVALENT(1'b0), .ACTIVE_HIGH(1'b1)) u_dron (
        .clk_sys(CLK_SYS),
        .reset_n(RESET_N),
        .ch_a(FAILSAFE_INPUT_MODULE[SSC_CH_DRON_A]),
        .ch_b(FAILSAFE_INPUT_MODULE[SSC_CH_DRON_B]),
        .active_reg(DRIVES_ON_PRESSED),
        .discrepancy_reg(SENSOR_DISCREPANCY[3])
    );

    // each output pair switched on its own command only
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            FAILSAFE_OUT_P <= '0;
            FAILSAFE_OUT_M <= '0;
            VALVE_FLOW <= 1'b0;
        end else begin
            FAILSAFE_OUT_P <= FAILSAFE_OUT_CMD;
            FAILSAFE_OUT_M <= FAILSAFE_OUT_CMD;
            VALVE_FLOW <= FAILSAFE_OUT_CMD[SSC_FDO_VALVE];
        end
    end

    // assertions
    property mismatch_flag_p;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        mismatch[0] |=> DISCREPANCY_FAULT[0];
    endproperty
    mismatch_flag_a: assert property (mismatch_flag_p)
        else $error("channel mismatch not flagged");

    brake_on_standstill_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (both_standstill[0] || MONITOR_PULSE_CANCEL[0]) |=> !SAFE_BRAKE_CTRL[0])
        else $error("brake not engaged on standstill");

    brake_needs_run_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        SAFE_BRAKE_CTRL[0] |-> PULSES_ENABLED[0])
        else $error("brake released without pulses");

    // the inhibit-clear and power-up restart steps must each be taken on their own power-on edge
    sequence inhibit_cleared_s;
        (rs_reg[0] == SSC_RS_WAIT_LOW) ##1 (rs_reg[0] == SSC_RS_WAIT_HIGH);
    endsequence
    sequence powered_up_s;
        (rs_reg[0] == SSC_RS_WAIT_HIGH) ##1 (rs_reg[0] == SSC_RS_RUN);
    endsequence
    run_needs_rise_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        $rose(PULSES_ENABLED[0]) |-> $past(pwr_rise[0]))
        else $error("run without rising power-on edge");

    inhibit_clear_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        inhibit_cleared_s |-> $past(pwr_fall[0]))
        else $error("power-on inhibit cleared without falling edge");

    restart_order_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        powered_up_s |-> $past(pwr_rise[0]))
        else $error("drive powered up without rising edge");

    cu_status_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (CU_STANDSTILL_ENABLE[0] && !cu_select[0]) |=> CU_SAFETY_STATUS[0])
        else $error("de-energized input not standstill");

    disabled_free_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        !CU_STANDSTILL_ENABLE[0] |=> (GENERAL_DI_FREE[0] && !CU_SAFETY_STATUS[0]))
        else $error("disabled supervision claims input");

    combined_status_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        COMBINED_SAFETY_STATUS[0] |-> (CU_SAFETY_STATUS[0] && MM_SAFETY_STATUS[0]))
        else $error("combined status inconsistent");

    valve_follow_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        ##1 VALVE_FLOW == $past(FAILSAFE_OUT_CMD[SSC_FDO_VALVE]))
        else $error("valve output wrong");

    estop_pressed_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (!FAILSAFE_INPUT_MODULE[SSC_CH_ESTOP_A] || !FAILSAFE_INPUT_MODULE[SSC_CH_ESTOP_B])
        |=> ESTOP_PRESSED)
        else $error("estop not seen pressed");

    mm_status_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (MM_STANDSTILL_ENABLE[0] && !PULSE_ENABLE_TERMINAL[0]) |=> MM_SAFETY_STATUS[0])
        else $error("pulse-enable terminal low not standstill");

    group_covers_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        cu_standstill[0] |=> GROUP_SAFETY_STATUS[0])
        else $error("group status misses own standstill");

    fault_local_a: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (DRIVE_FAULT[0] && !group_standstill[0]) |=> !GROUP_SAFETY_STATUS[0])
        else $error("drive fault spread into group status");
endmodule

//--- verif/ssc_safety_ctrl.sv
// far-side safety controller model feeding both standstill channels
module ssc_safety_ctrl (
    input wire logic [7:0] aux_in,
    input wire logic [1:0] grp_rel,
    input wire logic [3:0] skew,
    output logic [7:0] di_out,
    output logic [3:0] pet_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // group a: drives 0,1 on input 2; group b: drives 2,3 on input 5
    always_comb begin
        di_out = aux_in;
        di_out[2] = grp_rel[0];
        di_out[5] = grp_rel[1];
        // skew breaks channel agreement only when a scenario asks for it
        pet_out = {{2{grp_rel[1]}}, {2{grp_rel[0]}}} ^ skew;
    end
endmodule

//--- verif/ssc_top_test.sv
// self-checking bench for the safe standstill block with a cycle model
module ssc_top_test import ssc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] aux = 8'h00, fsi = 8'h00;
    logic [11:0] sel = 12'h000;
    logic [3:0] skew = 4'h0, cu_en = 4'h0, mm_en = 4'h0, den = 4'h0, pon = 4'h0;
    logic [3:0] dflt = 4'h0, mpc = 4'h0, fcmd = 4'h0;
    logic [1:0] grp = 2'h0;
    logic [7:0] di, di_gen, x_dig;
    logic [3:0] pet, cu_st, mm_st, cmb_st, grp_st, dsc, pen, safe_brake_ctrl, gfree, sdsc, fo_p, fo_m;
    logic [3:0] x_cu, x_mm, x_cmb, x_grp, x_dsc, x_pen, x_gf, x_sd, x_fo, cin;
    logic [3:0] x_cx, cex, cu_st_exp, ppon;
    logic estop, door, agree, dron, valve, x_es, x_door, x_agr, x_dron;
    int st[4];
    int seed = 57;
    int failures = 0, num_checks = 0;
    bit started = 1'b0;

    initial begin
        forever #2 clk = ~clk;
    end

    ssc_safety_ctrl ssc_safety_ctrl_i (.aux_in(aux), .grp_rel(grp), .skew(skew),
        .di_out(di), .pet_out(pet));

    ssc_top ssc_top_i (.CLK_SYS(clk), .RESET_N(rst_n), .DIGITAL_IN(di),
        .STANDSTILL_SOURCE_SELECT(sel), .PULSE_ENABLE_TERMINAL(pet),
        .CU_STANDSTILL_ENABLE(cu_en), .MM_STANDSTILL_ENABLE(mm_en), .DRIVE_ENABLE(den),
        .POWER_ON_COMMAND(pon), .DRIVE_FAULT(dflt), .MONITOR_PULSE_CANCEL(mpc),
        .FAILSAFE_INPUT_MODULE(fsi), .FAILSAFE_OUT_CMD(fcmd), .CU_SAFETY_STATUS(cu_st),
        .MM_SAFETY_STATUS(mm_st), .COMBINED_SAFETY_STATUS(cmb_st),
        .GROUP_SAFETY_STATUS(grp_st), .DISCREPANCY_FAULT(dsc), .PULSES_ENABLED(pen),
        .SAFE_BRAKE_CTRL(safe_brake_ctrl), .GENERAL_DI_FREE(gfree), .DIGITAL_IN_GENERAL(di_gen),
        .ESTOP_PRESSED(estop), .DOOR_INTERLOCKED(door), .AGREEMENT_PRESSED(agree),
        .DRIVES_ON_PRESSED(dron), .SENSOR_DISCREPANCY(sdsc), .FAILSAFE_OUT_P(fo_p),
        .FAILSAFE_OUT_M(fo_m), .VALVE_FLOW(valve));

    // small variant: selectors 4..7 must read as de-energized
    ssc_top #(.EXPANSION_UNIT(1'b1)) ssc_top_exp_i (.CLK_SYS(clk), .RESET_N(rst_n),
        .DIGITAL_IN(di), .STANDSTILL_SOURCE_SELECT(sel), .PULSE_ENABLE_TERMINAL(pet),
        .CU_STANDSTILL_ENABLE(cu_en), .MM_STANDSTILL_ENABLE(mm_en), .DRIVE_ENABLE(den),
        .POWER_ON_COMMAND(pon), .DRIVE_FAULT(dflt), .MONITOR_PULSE_CANCEL(mpc),
        .FAILSAFE_INPUT_MODULE(fsi), .FAILSAFE_OUT_CMD(fcmd), .CU_SAFETY_STATUS(cu_st_exp),
        .MM_SAFETY_STATUS(), .COMBINED_SAFETY_STATUS(), .GROUP_SAFETY_STATUS(),
        .DISCREPANCY_FAULT(), .PULSES_ENABLED(), .SAFE_BRAKE_CTRL(), .GENERAL_DI_FREE(),
        .DIGITAL_IN_GENERAL(), .ESTOP_PRESSED(), .DOOR_INTERLOCKED(), .AGREEMENT_PRESSED(),
        .DRIVES_ON_PRESSED(), .SENSOR_DISCREPANCY(), .FAILSAFE_OUT_P(), .FAILSAFE_OUT_M(),
        .VALVE_FLOW());

    // reference model, evaluated on the inputs present at each edge
    always @(posedge clk) begin
        started = 1'b1;
        if (!rst_n) begin
            {x_cu, x_mm, x_cmb, x_grp} = 16'hffff;
            {x_dsc, x_pen, x_gf, x_sd, x_fo, x_dig} = 28'h000_0000;
            {x_es, x_door, x_agr, x_dron} = 4'h8;
            x_cx = 4'hf;
            ppon = 4'h0;
            st = '{default: 0};
        end else begin
            for (int d = 0; d < 4; d++) begin
                cin[d] = di[sel[3*d +: 3]];
                cex[d] = (sel[3*d +: 3] < 3'h4) ? cin[d] : 1'b0;
                x_cx[d] = cu_en[d] & ~cex[d];
                x_cu[d] = cu_en[d] & ~cin[d];
                x_mm[d] = mm_en[d] & ~pet[d];
                x_dsc[d] = cu_en[d] & mm_en[d] & (cin[d] != pet[d]);
            end
            x_cmb = x_cu & x_mm;
            for (int d = 0; d < 4; d++) begin
                x_grp[d] = x_cu[d] | x_mm[d];
                for (int e = 0; e < 4; e++) begin
                    if (sel[3*e +: 3] == sel[3*d +: 3]) x_grp[d] |= x_cu[e];
                end
                // a fault holds only its own drive, never its group partners
                if (x_cu[d] | x_mm[d] | x_dsc[d] | dflt[d]
                    | mpc[d] | ~den[d]) begin
                    st[d] = 0;
                end else if (st[d] == 0) begin
                    st[d] = 1;
                end else if (st[d] == 1 && !pon[d] && ppon[d]) begin
                    st[d] = 2;
                end else if (st[d] == 2 && pon[d] && !ppon[d]) begin
                    st[d] = 3;
                end
                x_pen[d] = (st[d] == 3);
            end
            x_gf = ~cu_en;
            x_dig = di;
            x_es = ~(fsi[SSC_CH_ESTOP_A] & fsi[SSC_CH_ESTOP_B]);
            x_door = fsi[SSC_CH_DOOR_A] & fsi[SSC_CH_DOOR_B];
            x_agr = fsi[SSC_CH_AGREE_A] & ~fsi[SSC_CH_AGREE_B];
            x_dron = fsi[SSC_CH_DRON_A] & fsi[SSC_CH_DRON_B];
            x_sd = {fsi[3] != fsi[7], fsi[2] == fsi[6],
                fsi[1] != fsi[5], fsi[0] != fsi[4]};
            x_fo = fcmd;
            // edges are seen against the command held at the previous edge
            ppon = pon;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    always @(negedge clk) begin
        if (started) begin
            check(32'({cu_st, mm_st}), 32'({x_cu, x_mm}));
            check(32'(cu_st_exp), 32'(x_cx));
            check(32'({cmb_st, grp_st}), 32'({x_cmb, x_grp}));
            check(32'(dsc), 32'(x_dsc));
            check(32'({pen, safe_brake_ctrl}), 32'({x_pen, x_pen}));
            check(32'({gfree, di_gen}), 32'({x_gf, x_dig}));
            check(32'({estop, door}), 32'({x_es, x_door}));
            check(32'({agree, dron}), 32'({x_agr, x_dron}));
            check(32'(sdsc), 32'(x_sd));
            check(32'({fo_p, fo_m, valve}), 32'({x_fo, x_fo, x_fo[SSC_FDO_VALVE]}));
        end
    end

    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    initial begin
        logic [31:0] r;
        cyc(6);
        rst_n = 1'b1;
        // random traffic: grouping, skew, faults and power edges all move
        repeat (600) begin
            r = $random(seed);
            // low channel half stands for supply a contacts, high half for supply b
            {aux, fsi, sel[7:0], fcmd, pon} = r;
            r = $random(seed);
            {grp, sel[11:8], skew, cu_en, mm_en, den, dflt, mpc} = r[29:0];
            skew = skew & r[31:28];
            dflt = dflt & r[31:28];
            mpc = mpc & r[31:28];
            den = den | r[31:28];
            cyc(1);
        end
        // directed restart: groups released on both channels, then power edges
        {sel, skew, dflt, mpc, cu_en, mm_en, den, grp, pon} = {12'hb52, 12'h000, 12'hfff, 6'h3f};
        cyc(3);
        pon = 4'h0;
        cyc(2);
        pon = 4'hf;
        for (int i = 0; i <= 8 && pen !== 4'hf; i++) cyc(1);
        check(32'(pen), 32'h0000_000f);
        dflt = 4'h1;
        cyc(2);
        check(32'(pen), 32'h0000_000e);
        mpc = 4'h8;
        cyc(2);
        check(32'(safe_brake_ctrl), 32'h0000_0006);
        grp = 2'h2;
        cyc(2);
        // group a stands; drive 2 of group b keeps running
        check(32'({cu_st, pen}), 32'h0000_0034);
        cyc(2);
        print_verdict();
    end

    initial begin
        cyc(5000);
        failures++;
        print_verdict();
    end
endmodule
